/* verilog/optical_ctrl_consts.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef OPTICAL_CTRL_CONSTS_SVH
`define OPTICAL_CTRL_CONSTS_SVH
`define OFS_FIFO_CFG 8'h08
`define OFS_MODE_PRIMARY 8'h09
`define OFS_MODE_TIMING 8'h0A
`define OFS_EMIT1_AMP 8'h0C
`define OFS_EMIT2_AMP 8'h0D
`define OFS_EMIT3_AMP 8'h0E
`define OFS_EMIT4_AMP 8'h0F
`define OFS_EMIT_RANGE 8'h11
`define OFS_REDUCED_AMP 8'h12
`define OFS_SLOT_SEL12 8'h13
`define OFS_SLOT_SEL34 8'h14
`define OFS_IRQ_STATUS 8'h00
`define RST_FIFO_CFG 8'h0F
`define RST_ZERO 8'h00
`define BIT_POWER_SAVE 7
`define BIT_SOFT_RESET 6
`define BIT_AMB_DETECT 2
`define BIT_AFULL_FLAG 7
`define BIT_PWR_FLAG 0
`define MASK_MODE_PRIMARY 8'hDF
`define FIFO_DEPTH 6'h20
`define CLK_HZ 20000000
`define SOFT_RESET_CYCLES 16
`endif

/* verilog/optical_ctrl_pkg.sv */
// Types shared by the optical sampling control files.
`default_nettype none
package optical_ctrl_pkg;
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_ONE = 2'b01,
        MODE_TWO = 2'b10,
        MODE_FLEX = 2'b11
    } conv_mode_e;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_PULSE = 2'b01,
        SEQ_WAIT = 2'b10
    } seq_state_e;
endpackage : optical_ctrl_pkg
`default_nettype wire

/* verilog/slot_decode.sv */
// Decoder of one flex slot selector into emitter choice and amplitude source.
`default_nettype none
module slot_decode (
    input wire logic [3:0] code_i,
    output logic active_o,
    output logic [1:0] emitter_o,
    output logic reduced_o
);
    // Codes 1-4 pick an emitter at its own level, 5-8 at the reduced level.
    always_comb
    begin
        active_o = (code_i >= 4'h1) && (code_i <= 4'h8);
        reduced_o = (code_i >= 4'h5) && (code_i <= 4'h8);
        emitter_o = reduced_o ? 2'(code_i - 4'h5) : 2'(code_i - 4'h1);
        if (!active_o)
        begin
            emitter_o = 2'h0;
        end
    end
endmodule : slot_decode
`default_nettype wire

/* verilog/rate_timer.sv */
// Sample period timer: one pulse per sample at the selected rate.
`default_nettype none
module rate_timer #(
    parameter int CLK_HZ = 20000000
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic [2:0] rate_i,
    output logic tick_o
);
    logic [19:0] cnt_r;
    logic [19:0] cnt_nxt;
    logic [19:0] period;
    logic tick_nxt;
    // Period in clocks for each rate code.
    always_comb
    begin
        unique case (rate_i)
            3'h0: period = 20'(CLK_HZ / 50);
            3'h1: period = 20'(CLK_HZ / 100);
            3'h2: period = 20'(CLK_HZ / 200);
            3'h3: period = 20'(CLK_HZ / 400);
            3'h4: period = 20'(CLK_HZ / 800);
            3'h5: period = 20'(CLK_HZ / 1000);
            3'h6: period = 20'(CLK_HZ / 1600);
            3'h7: period = 20'(CLK_HZ / 3200);
        endcase
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r;
        if (!run_i)
        begin
            cnt_nxt = 20'h00000;
        end
        else if (cnt_r >= period - 20'h00001)
        begin
            cnt_nxt = 20'h00000;
            tick_nxt = 1'b1;
        end
        else
        begin
            cnt_nxt = cnt_r + 20'h00001;
        end
    end
    // Registers the counter and pulse.
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_r <= 20'h00000;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_o <= tick_nxt;
        end
    end
endmodule : rate_timer
`default_nettype wire

/* verilog/optical_ctrl.sv */
// Mode, timing, amplitude and power control of the optical sampling core.
`default_nettype none
`include "optical_ctrl_consts.svh"

module optical_ctrl #(
    parameter int CLK_HZ = `CLK_HZ,
    parameter int SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [5:0] unread_count_i,
    input wire logic undervolt_evt_i,
    output logic [7:0] rdata_o,
    output logic afull_flag_o,
    output logic osc_enable_o,
    output logic cancel_loop_en_o,
    output logic filter_en_o,
    output logic pulse_o,
    output logic [1:0] pulse_emitter_o,
    output logic [7:0] pulse_amplitude_o,
    output logic [1:0] pulse_range_o,
    output logic [1:0] pulse_width_sel_o,
    output logic [1:0] conv_span_o,
    output logic buffer_push_o
);
    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [7:0] fifo_cfg_r, fifo_cfg_nxt;
    logic [7:0] mode_primary_r, mode_primary_nxt;
    logic [7:0] mode_timing_r, mode_timing_nxt;
    logic [7:0] amp_r [4];
    logic [7:0] amp_nxt [4];
    logic [7:0] range_r, range_nxt;
    logic [7:0] reduced_r, reduced_nxt;
    logic [15:0] slots_r, slots_nxt;
    logic afull_r, afull_nxt;
    logic pwr_flag_r, pwr_flag_nxt;
    logic [7:0] srst_cnt_r, srst_cnt_nxt;
    logic [7:0] rdata_nxt;
    logic in_reset;
    logic power_save;
    logic power_save_d_r;
    logic afull_hit;
    logic run;
    logic tick;

    assign power_save = mode_primary_r[`BIT_POWER_SAVE];
    assign in_reset = mode_primary_r[`BIT_SOFT_RESET];
    assign run = !power_save && !in_reset
        && (optical_ctrl_pkg::conv_mode_e'(mode_primary_r[1:0]) != optical_ctrl_pkg::MODE_OFF);
    assign afull_hit = unread_count_i >= (`FIFO_DEPTH - {2'h0, fifo_cfg_r[3:0]});

    // Register writes, soft reset sequence and interrupt flags.
    always_comb
    begin
        fifo_cfg_nxt = fifo_cfg_r;
        mode_primary_nxt = mode_primary_r;
        mode_timing_nxt = mode_timing_r;
        amp_nxt = amp_r;
        range_nxt = range_r;
        reduced_nxt = reduced_r;
        slots_nxt = slots_r;
        srst_cnt_nxt = srst_cnt_r;
        afull_nxt = afull_r;
        pwr_flag_nxt = pwr_flag_r | undervolt_evt_i;
        // Reading status clears flags, but a coincident event wins.
        if (rd_en_i && addr_i == `OFS_IRQ_STATUS)
        begin
            afull_nxt = 1'b0;
            pwr_flag_nxt = undervolt_evt_i;
        end
        if (afull_hit && !power_save)
        begin
            afull_nxt = 1'b1;
        end
        if (power_save)
        begin
            afull_nxt = 1'b0;
            pwr_flag_nxt = 1'b0;
        end
        if (in_reset)
        begin
            // Forced reset: all registers to defaults, power flag kept.
            fifo_cfg_nxt = `RST_FIFO_CFG;
            mode_primary_nxt = 8'h40;
            mode_timing_nxt = `RST_ZERO;
            for (int i = 0; i < 4; i++)
            begin
                amp_nxt[i] = `RST_ZERO;
            end
            range_nxt = `RST_ZERO;
            reduced_nxt = `RST_ZERO;
            slots_nxt = 16'h0000;
            afull_nxt = 1'b0;
            srst_cnt_nxt = srst_cnt_r + 8'h01;
            if (srst_cnt_r >= 8'(SOFT_RESET_CYCLES - 1))
            begin
                mode_primary_nxt = `RST_ZERO;
                srst_cnt_nxt = 8'h00;
            end
        end
        else if (wr_en_i)
        begin
            // Writes stay accepted in power save.
            unique case (addr_i)
                `OFS_FIFO_CFG: fifo_cfg_nxt = wdata_i;
                `OFS_MODE_PRIMARY: mode_primary_nxt = wdata_i & `MASK_MODE_PRIMARY;
                `OFS_MODE_TIMING: mode_timing_nxt = wdata_i;
                `OFS_EMIT1_AMP: amp_nxt[0] = wdata_i;
                `OFS_EMIT2_AMP: amp_nxt[1] = wdata_i;
                `OFS_EMIT3_AMP: amp_nxt[2] = wdata_i;
                `OFS_EMIT4_AMP: amp_nxt[3] = wdata_i;
                `OFS_EMIT_RANGE: range_nxt = wdata_i;
                `OFS_REDUCED_AMP: reduced_nxt = wdata_i;
                `OFS_SLOT_SEL12: slots_nxt[7:0] = wdata_i;
                `OFS_SLOT_SEL34: slots_nxt[15:8] = wdata_i;
                default: ;
            endcase
        end
    end

    // Read data, registered one cycle after the read strobe.
    always_comb
    begin
        rdata_nxt = 8'h00;
        unique case (addr_i)
            `OFS_IRQ_STATUS: rdata_nxt = {afull_r, 6'h00, pwr_flag_r};
            `OFS_FIFO_CFG: rdata_nxt = fifo_cfg_r;
            `OFS_MODE_PRIMARY: rdata_nxt = mode_primary_r;
            `OFS_MODE_TIMING: rdata_nxt = mode_timing_r;
            `OFS_EMIT1_AMP: rdata_nxt = amp_r[0];
            `OFS_EMIT2_AMP: rdata_nxt = amp_r[1];
            `OFS_EMIT3_AMP: rdata_nxt = amp_r[2];
            `OFS_EMIT4_AMP: rdata_nxt = amp_r[3];
            `OFS_EMIT_RANGE: rdata_nxt = range_r;
            `OFS_REDUCED_AMP: rdata_nxt = reduced_r;
            `OFS_SLOT_SEL12: rdata_nxt = slots_r[7:0];
            `OFS_SLOT_SEL34: rdata_nxt = slots_r[15:8];
            default: rdata_nxt = 8'h00;
        endcase
        if (!rd_en_i)
        begin
            rdata_nxt = rdata_o;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    optical_ctrl_pkg::seq_state_e state_r, state_nxt;
    logic [1:0] slot_r, slot_nxt;
    logic [5:0] avg_cnt_r, avg_cnt_nxt;
    logic [5:0] avg_len;
    logic [1:0] slot_last;
    logic slot_on [4];
    logic [1:0] slot_em [4];
    logic slot_red [4];
    logic pulse_nxt;
    logic [1:0] em_nxt;
    logic [7:0] amp_sel_nxt;
    logic push_nxt;

    // One decoder per flex slot.
    for (genvar g = 0; g < 4; g++)
    begin : g_slot
        slot_decode u_dec (
            .code_i(slots_r[4 * g +: 4]),
            .active_o(slot_on[g]),
            .emitter_o(slot_em[g]),
            .reduced_o(slot_red[g])
        );
    end

    rate_timer #(
        .CLK_HZ(CLK_HZ)
    ) u_timer (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .run_i(run),
        .rate_i(mode_timing_r[4:2]),
        .tick_o(tick)
    );

    // Steps through the slots of one sample and counts averages.
    always_comb
    begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        avg_cnt_nxt = avg_cnt_r;
        pulse_nxt = 1'b0;
        em_nxt = pulse_emitter_o;
        amp_sel_nxt = pulse_amplitude_o;
        push_nxt = 1'b0;
        avg_len = (fifo_cfg_r[7:5] >= 3'h5) ? 6'h20 : 6'(6'h01 << fifo_cfg_r[7:5]);
        unique case (optical_ctrl_pkg::conv_mode_e'(mode_primary_r[1:0]))
            optical_ctrl_pkg::MODE_OFF: slot_last = 2'h0;
            optical_ctrl_pkg::MODE_ONE: slot_last = 2'h0;
            optical_ctrl_pkg::MODE_TWO: slot_last = 2'h1;
            optical_ctrl_pkg::MODE_FLEX: slot_last = 2'h3;
        endcase
        unique case (state_r)
            optical_ctrl_pkg::SEQ_IDLE:
            begin
                slot_nxt = 2'h0;
                if (tick && run)
                begin
                    state_nxt = optical_ctrl_pkg::SEQ_PULSE;
                end
            end
            optical_ctrl_pkg::SEQ_PULSE:
            begin
                if (mode_primary_r[1:0] == 2'b11)
                begin
                    pulse_nxt = slot_on[slot_r];
                    em_nxt = slot_em[slot_r];
                    amp_sel_nxt = slot_red[slot_r] ? reduced_r : amp_r[slot_em[slot_r]];
                end
                else
                begin
                    pulse_nxt = 1'b1;
                    em_nxt = slot_r;
                    amp_sel_nxt = amp_r[slot_r];
                end
                if (!run)
                begin
                    pulse_nxt = 1'b0;
                    state_nxt = optical_ctrl_pkg::SEQ_IDLE;
                end
                else if (slot_r == slot_last)
                begin
                    state_nxt = optical_ctrl_pkg::SEQ_WAIT;
                end
                else
                begin
                    slot_nxt = slot_r + 2'h1;
                end
            end
            optical_ctrl_pkg::SEQ_WAIT:
            begin
                state_nxt = optical_ctrl_pkg::SEQ_IDLE;
                if (avg_cnt_r + 6'h01 >= avg_len)
                begin
                    avg_cnt_nxt = 6'h00;
                    push_nxt = 1'b1;
                end
                else
                begin
                    avg_cnt_nxt = avg_cnt_r + 6'h01;
                end
            end
            default: state_nxt = optical_ctrl_pkg::SEQ_IDLE;
        endcase
        if (!run)
        begin
            avg_cnt_nxt = 6'h00;
        end
    end

    // Registers all state except the static outputs.
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            fifo_cfg_r <= `RST_FIFO_CFG;
            mode_primary_r <= `RST_ZERO;
            mode_timing_r <= `RST_ZERO;
            amp_r <= '{default: 8'h00};
            range_r <= `RST_ZERO;
            reduced_r <= `RST_ZERO;
            slots_r <= 16'h0000;
            afull_r <= 1'b0;
            pwr_flag_r <= 1'b0;
            srst_cnt_r <= 8'h00;
            rdata_o <= 8'h00;
            state_r <= optical_ctrl_pkg::SEQ_IDLE;
            slot_r <= 2'h0;
            avg_cnt_r <= 6'h00;
            pulse_o <= 1'b0;
            pulse_emitter_o <= 2'h0;
            pulse_amplitude_o <= 8'h00;
            buffer_push_o <= 1'b0;
            power_save_d_r <= 1'b0;
        end
        else
        begin
            fifo_cfg_r <= fifo_cfg_nxt;
            mode_primary_r <= mode_primary_nxt;
            mode_timing_r <= mode_timing_nxt;
            amp_r <= amp_nxt;
            range_r <= range_nxt;
            reduced_r <= reduced_nxt;
            slots_r <= slots_nxt;
            afull_r <= afull_nxt;
            pwr_flag_r <= pwr_flag_nxt;
            srst_cnt_r <= srst_cnt_nxt;
            rdata_o <= rdata_nxt;
            state_r <= state_nxt;
            slot_r <= slot_nxt;
            avg_cnt_r <= avg_cnt_nxt;
            pulse_o <= pulse_nxt;
            pulse_emitter_o <= em_nxt;
            pulse_amplitude_o <= amp_sel_nxt;
            buffer_push_o <= push_nxt;
            power_save_d_r <= power_save;
        end
    end

    // Static outputs decoded from configuration, plus the almost-full flag from its next value, registered.
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            afull_flag_o <= 1'b0;
            osc_enable_o <= 1'b0;
            cancel_loop_en_o <= 1'b0;
            filter_en_o <= 1'b0;
            pulse_range_o <= 2'h0;
            pulse_width_sel_o <= 2'h0;
            conv_span_o <= 2'h0;
        end
        else
        begin
            afull_flag_o <= afull_nxt;
            osc_enable_o <= !mode_primary_nxt[`BIT_POWER_SAVE];
            cancel_loop_en_o <= !mode_primary_nxt[`BIT_AMB_DETECT];
            filter_en_o <= !mode_primary_nxt[`BIT_AMB_DETECT];
            pulse_range_o <= range_r[2 * em_nxt +: 2];
            pulse_width_sel_o <= mode_timing_nxt[1:0];
            conv_span_o <= mode_timing_nxt[6:5];
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_save_on;
        power_save && !power_save_d_r;
    endsequence
    a_save_clears_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        s_save_on |=> !afull_flag_o) else $error("flag kept in power save");
    a_no_pulse_save: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        power_save |-> ##2 !pulse_o) else $error("pulse in power save");
    a_soft_reset_ends: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(in_reset) |-> ##[1:300] !in_reset) else $error("reset bit stuck");
    a_osc_follows: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> osc_enable_o == !power_save) else $error("oscillator enable wrong");
    a_filter_follow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> filter_en_o == !mode_primary_r[`BIT_AMB_DETECT]) else $error("filter");
    a_afull_level: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        afull_hit && !power_save && !in_reset |=> afull_flag_o) else $error("almost full missed");
    a_off_no_pulse: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        mode_primary_r[1:0] == 2'b00 |-> ##2 !pulse_o) else $error("pulse when off");
    a_reset_defaults: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        in_reset |=> fifo_cfg_r == `RST_FIFO_CFG) else $error("reset value");
endmodule : optical_ctrl
`default_nettype wire

/* verification/sample_buffer_model.sv */
// Stand-in for the sample buffer that counts the averaged samples pushed into it.
`default_nettype none
module sample_buffer_model (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic push_i,
    input wire logic drain_i,
    output logic [5:0] unread_count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Count pushes; a full buffer drops new samples and drain empties it.
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            unread_count_o <= 6'h00;
        else if (drain_i)
            unread_count_o <= 6'h00;
        else if (push_i && unread_count_o < 6'h20)
            unread_count_o <= unread_count_o + 6'h01;
    end
endmodule : sample_buffer_model
`default_nettype wire

/* verification/optical_sampling_mode_control_test.sv */
// Self-checking bench for the optical sampling mode control block.
`default_nettype none
module optical_sampling_mode_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 30000;
    localparam logic [7:0] OFS [5] = '{8'h08, 8'h09, 8'h0A, 8'h0C, 8'h30};
    localparam logic [7:0] DEF [5] = '{8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
    logic mclk_i, rstn_i, wr_en, rd_en, undervolt, drain;
    logic [7:0] addr, wdata, rdata, v, amp;
    logic [5:0] unread;
    logic afull, osc, cancel_en, filt_en, pulse, push;
    logic [1:0] emit, rng, pw, span;
    int errors = 0, n_compared = 0, cyc = 0, n_pulse = 0, n_push = 0;
    int pulse_gap, push_gap, last_pulse, last_push, snap;
    logic [11:0] q[$];

    optical_ctrl #(.CLK_HZ(3200), .SOFT_RESET_CYCLES(4)) dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .unread_count_i(unread),
        .undervolt_evt_i(undervolt), .rdata_o(rdata), .afull_flag_o(afull),
        .osc_enable_o(osc), .cancel_loop_en_o(cancel_en), .filter_en_o(filt_en),
        .pulse_o(pulse), .pulse_emitter_o(emit), .pulse_amplitude_o(amp),
        .pulse_range_o(rng), .pulse_width_sel_o(pw), .conv_span_o(span),
        .buffer_push_o(push));
    sample_buffer_model buffer (.mclk_i(mclk_i), .rstn_i(rstn_i), .push_i(push),
        .drain_i(drain), .unread_count_o(unread));

    // Free-running clock of 50 ns.
    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    // Log pulses and pushes with their spacing; a stuck run is cut short.
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (pulse === 1'b1)
        begin
            q.push_back({emit, rng, amp});
            n_pulse <= n_pulse + 1;
            pulse_gap <= cyc - last_pulse;
            last_pulse <= cyc;
        end
        if (push === 1'b1)
        begin
            n_push <= n_push + 1;
            push_gap <= cyc - last_push;
            last_push <= cyc;
        end
        if (cyc == LIMIT)
        begin
            errors++;
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // Access and comparison tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One write, then an idle cycle so strobes never toggle twice in a step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk_i);
        wr_en <= 1'b0;
        @(posedge mclk_i);
    endtask : wr

    // Read data lands on the taking edge and then holds.
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk_i);
        rd_en <= 1'b0;
        repeat (2) @(posedge mclk_i);
        v = rdata;
    endtask : rd

    task automatic wait_for(input int which, input int n);
        int start;
        start = (which == 0) ? n_pulse : n_push;
        for (int i = 0; i < 3000; i++)
        begin
            @(posedge mclk_i);
            if (((which == 0) ? n_pulse : n_push) >= start + n)
                break;
        end
    endtask : wait_for

    task automatic wait_count(input logic [5:0] n);
        for (int i = 0; i < 3000 && unread !== n; i++)
            @(posedge mclk_i);
        repeat (3) @(posedge mclk_i);
    endtask : wait_count

    task automatic check_defaults;
        foreach (OFS[i])
        begin
            rd(OFS[i]);
            check(v, DEF[i]);
        end
    endtask : check_defaults

    // Stop sampling, empty the buffer and clear the status flags.
    task automatic quiet;
        wr(8'h09, 8'h00);
        repeat (8) @(posedge mclk_i);
        drain <= 1'b1;
        @(posedge mclk_i);
        drain <= 1'b0;
        rd(8'h00);
        q.delete();
    endtask : quiet

    // Flag stays low one sample short of the threshold, then rises.
    task automatic afull_run(input logic [3:0] lvl);
        quiet();
        wr(8'h08, {4'h0, lvl});
        wr(8'h09, 8'h01);
        wait_count(6'd31 - lvl);
        check(afull, 0);
        wait_count(6'd32 - lvl);
        check(afull, 1);
    endtask : afull_run

    task automatic seq_run(input logic [7:0] m, input int n, input logic [11:0] e0,
                           input logic [11:0] e1);
        quiet();
        wr(8'h09, m);
        wait_for(0, 1);
        repeat (40) @(posedge mclk_i);
        check(q.size(), n);
        check(q[0], e0);
        if (n > 1)
            check(q[1], e1);
    endtask : seq_run

    task automatic close_out;
        $display("Counts: %0d compared, %0d errors", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rstn_i <= 1'b0;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        addr <= 8'h00;
        wdata <= 8'h00;
        undervolt <= 1'b0;
        drain <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        check_defaults();
        check({afull, osc}, 1);
        wr(8'h0A, 8'hFF);
        rd(8'h0A);
        check(v, 8'hFF);
        $display("Test defaults done");
        wr(8'h09, 8'h24);
        check({cancel_en, filt_en}, 0);
        rd(8'h09);
        check(v, 8'h04);
        wr(8'h09, 8'h00);
        check({cancel_en, filt_en}, 3);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h0A, {1'b0, k[1:0], 3'b000, k[1:0]});
            check({span, pw}, {k[1:0], k[1:0]});
        end
        $display("Test fields done");
        wr(8'h09, 8'h01);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h0A, {3'b000, k[2:0], 2'b00});
            wait_for(0, 3);
            check(pulse_gap, 64 >> k);
        end
        wr(8'h0A, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h08, {k[2:0], 5'h0F});
            wait_for(1, 3);
            check(push_gap, 64 << k);
        end
        $display("Test rates done");
        wr(8'h11, 8'hC6);
        wr(8'h0C, 8'h5A);
        wr(8'h0D, 8'h3C);
        wr(8'h0F, 8'hF1);
        wr(8'h12, 8'h21);
        wr(8'h13, 8'h45);
        wr(8'h14, 8'h90);
        seq_run(8'h01, 1, 12'h25A, 12'h000);
        seq_run(8'h02, 2, 12'h25A, 12'h53C);
        seq_run(8'h03, 2, 12'h221, 12'hFF1);
        $display("Test sequences done");
        afull_run(4'hF);
        afull_run(4'h0);
        $display("Test almost full done");
        wr(8'h09, 8'h00);
        drain <= 1'b1;
        undervolt <= 1'b1;
        @(posedge mclk_i);
        drain <= 1'b0;
        undervolt <= 1'b0;
        wr(8'h09, 8'h81);
        // The flag clears one edge after power save is stored, on the idle edge of wr; one more edge passes here.
        @(posedge mclk_i);
        check({afull, osc}, 0);
        rd(8'h00);
        check(v, 8'h00);
        wr(8'h0C, 8'hA5);
        rd(8'h0C);
        check(v, 8'hA5);
        rd(8'h09);
        check(v, 8'h81);
        snap = n_pulse;
        repeat (200) @(posedge mclk_i);
        check(n_pulse - snap, 0);
        wr(8'h09, 8'h01);
        repeat (200) @(posedge mclk_i);
        check({osc, n_pulse > snap}, 3);
        $display("Test power save done");
        undervolt <= 1'b1;
        @(posedge mclk_i);
        undervolt <= 1'b0;
        wr(8'h0A, 8'h55);
        wr(8'h08, 8'h3A);
        wr(8'h09, 8'h41);
        repeat (8) @(posedge mclk_i);
        check_defaults();
        rd(8'h00);
        check(v, 8'h01);
        $display("Test soft reset done");
        close_out();
    end
endmodule : optical_sampling_mode_control_test
`default_nettype wire
